//--- rtl/dcco_bank.sv
// Communication, error and command objects of the drive object dictionary
module dcco_bank #(
   parameter int AN_CHANNELS = 4
) (
   input wire logic clk,
   input wire logic reset,
   input dcco_pkg::dcco_req_t req,
   output dcco_pkg::dcco_rsp_t rsp,
   input wire logic restart,
   input wire logic [AN_CHANNELS*16-1:0] analog_in,
   input wire logic err_valid,
   input wire logic [15:0] err_code,
   input wire logic err_serious,
   output dcco_pkg::dcco_comm_t comm_active,
   output dcco_pkg::dcco_comm_t comm_stored,
   output logic [7:0] error_register,
   output logic history_push,
   output logic [15:0] history_code,
   output logic react_disable,
   output logic react_quick_stop,
   output dcco_pkg::dcco_cmd_t cmd,
   output logic [15:0] cmd_word
);
   import dcco_pkg::*;

   // ==========================================
   // Value checks
   function automatic logic ser_ok(input logic [7:0] c);
      ser_ok = (c <= SER_RATE_MAX);
   endfunction

   function automatic logic can_ok(input logic [7:0] c);
      // Defined but unsupported rates are refused at write time
      can_ok = (c <= CAN_RATE_MAX) && (c != CAN_RATE_10K) && (c != CAN_RATE_800K);
   endfunction

   function automatic logic id_ok(input logic [7:0] c);
      id_ok = (c >= NODE_ID_MIN) && (c <= NODE_ID_MAX);
   endfunction

   function automatic logic is_obj(input dcco_req_t r, input logic [15:0] idx);
      is_obj = (r.index == idx) && (r.sub == SUB_ZERO);
   endfunction

   // ==========================================
   // Storage
   dcco_comm_t stored_r;
   dcco_comm_t active_r;
   logic [15:0] action_r;
   logic [15:0] fault_r;
   logic [7:0] ereg_r;
   logic [15:0] cmd_r;
   logic push_r;
   logic [15:0] hist_r;
   logic disable_r;
   logic qstop_r;
   dcco_rsp_t rsp_r;
   logic [15:0] analog_r [AN_CHANNELS];

   logic [7:0] map_bits;
   logic [7:0] an_sel;

   // ==========================================
   // Access decode
   logic w_id;
   logic w_ser;
   logic w_can;
   logic w_act;
   logic w_cmd;
   logic acc_err;
   logic [15:0] rd_data;

   assign an_sel = req.sub - SUB_AN_FIRST;

   always_comb begin
      w_id = 1'b0;
      w_ser = 1'b0;
      w_can = 1'b0;
      w_act = 1'b0;
      w_cmd = 1'b0;
      acc_err = 1'b0;
      rd_data = 16'h0000;
      if (is_obj(req, IDX_NODE_ID)) begin
         rd_data = {8'h00, stored_r.node_id};
         w_id = req.write & id_ok(req.data[7:0]) & (req.data[15:8] == 8'h00);
         acc_err = req.write & ~w_id;
      end else if (is_obj(req, IDX_SER_RATE)) begin
         rd_data = {8'h00, stored_r.ser_rate};
         w_ser = req.write & ser_ok(req.data[7:0]) & (req.data[15:8] == 8'h00);
         acc_err = req.write & ~w_ser;
      end else if (is_obj(req, IDX_CAN_RATE)) begin
         rd_data = {8'h00, stored_r.can_rate};
         w_can = req.write & can_ok(req.data[7:0]) & (req.data[15:8] == 8'h00);
         acc_err = req.write & ~w_can;
      end else if (req.index == IDX_ANALOG && req.sub == SUB_ZERO) begin
         rd_data = {8'h00, SUB_AN_COUNT};
         acc_err = req.write;
      end else if (req.index == IDX_ANALOG && req.sub >= SUB_AN_FIRST &&
                   req.sub <= SUB_AN_LAST) begin
         rd_data = analog_r[an_sel[1:0]];
         acc_err = req.write;
      end else if (is_obj(req, IDX_ACTION)) begin
         rd_data = action_r;
         w_act = req.write;
      end else if (is_obj(req, IDX_FAULT)) begin
         rd_data = fault_r;
         acc_err = req.write;
      end else if (is_obj(req, IDX_CMD)) begin
         rd_data = cmd_r;
         w_cmd = req.write;
      end else begin
         acc_err = 1'b1;
      end
   end

   // ==========================================
   // Answer: one cycle after the request
   always_ff @(posedge clk) begin
      if (reset) begin
         rsp_r <= '0;
      end else begin
         rsp_r.ack <= req.valid;
         rsp_r.err <= req.valid & acc_err;
         rsp_r.data <= (req.valid && !req.write && !acc_err) ? rd_data : 16'h0000;
      end
   end

   // ==========================================
   // Stored communication settings
   always_ff @(posedge clk) begin
      if (reset) begin
         stored_r.node_id <= NODE_ID_RST;
         stored_r.ser_rate <= SER_RATE_RST;
         stored_r.can_rate <= CAN_RATE_RST;
      end else if (req.valid) begin
         if (w_id) begin
            stored_r.node_id <= req.data[7:0];
         end
         if (w_ser) begin
            stored_r.ser_rate <= req.data[7:0];
         end
         if (w_can) begin
            stored_r.can_rate <= req.data[7:0];
         end
      end
   end

   // ==========================================
   // Active settings, only refreshed by a restart
   always_ff @(posedge clk) begin
      if (reset) begin
         active_r.node_id <= NODE_ID_RST;
         active_r.ser_rate <= SER_RATE_RST;
         active_r.can_rate <= CAN_RATE_RST;
      end else if (restart) begin
         active_r <= stored_r;
      end
   end

   // ==========================================
   // Error action code and command word
   always_ff @(posedge clk) begin
      if (reset) begin
         action_r <= ACTION_RST;
      end else if (req.valid && w_act) begin
         action_r <= req.data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_r <= CMD_RST;
      end else if (req.valid && w_cmd) begin
         cmd_r <= req.data;
      end
   end

   // ==========================================
   // Analog sampling; copies make reads independent of input timing
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < AN_CHANNELS; i++) begin
            analog_r[i] <= 16'h0000;
         end
      end else begin
         for (int i = 0; i < AN_CHANNELS; i++) begin
            analog_r[i] <= analog_in[i*16 +: 16];
         end
      end
   end

   // ==========================================
   // Fault recording
   dcco_err_map u_map (
      .code(err_code),
      .ereg_bits(map_bits),
      .known()
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         fault_r <= FAULT_RST;
      end else if (err_valid) begin
         fault_r <= err_code;
      end
   end

   // A new error in the fault reset cycle wins over the clear
   always_ff @(posedge clk) begin
      if (reset) begin
         ereg_r <= 8'h00;
      end else if (err_valid) begin
         ereg_r <= map_bits;
      end else if (cmd.fault_reset) begin
         ereg_r <= 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         push_r <= 1'b0;
         hist_r <= 16'h0000;
      end else begin
         push_r <= err_valid;
         if (err_valid) begin
            hist_r <= err_code;
         end
      end
   end

   // ==========================================
   // Reaction to detected errors
   always_ff @(posedge clk) begin
      if (reset) begin
         disable_r <= 1'b0;
         qstop_r <= 1'b0;
      end else begin
         disable_r <= err_valid & (err_serious | (action_r == ACT_DISABLE));
         qstop_r <= err_valid & ~err_serious & (action_r == ACT_QSTOP);
      end
   end

   // ==========================================
   // Command decode
   dcco_cmd_decode u_cmd (
      .clk(clk),
      .reset(reset),
      .word(cmd_r),
      .cmd(cmd)
   );

   assign rsp = rsp_r;
   assign comm_active = active_r;
   assign comm_stored = stored_r;
   assign error_register = ereg_r;
   assign history_push = push_r;
   assign history_code = hist_r;
   assign react_disable = disable_r;
   assign react_quick_stop = qstop_r;
   assign cmd_word = cmd_r;
endmodule

//--- shared/dcco_pkg.sv
// Constants and carrier types for the drive communication object bank
package dcco_pkg;
   // ==========================================
   // Object indices and sub-indices
   localparam logic [15:0] IDX_NODE_ID = 16'h5000;
   localparam logic [15:0] IDX_SER_RATE = 16'h5001;
   localparam logic [15:0] IDX_CAN_RATE = 16'h5002;
   localparam logic [15:0] IDX_ANALOG = 16'h5010;
   localparam logic [15:0] IDX_ACTION = 16'h6007;
   localparam logic [15:0] IDX_FAULT = 16'h603f;
   localparam logic [15:0] IDX_CMD = 16'h6040;
   localparam logic [7:0] SUB_ZERO = 8'h00;
   localparam logic [7:0] SUB_AN_FIRST = 8'h01;
   localparam logic [7:0] SUB_AN_LAST = 8'h04;
   localparam logic [7:0] SUB_AN_COUNT = 8'h04;
   // ==========================================
   // Reset values and ranges
   localparam logic [7:0] NODE_ID_RST = 8'h01;
   localparam logic [7:0] NODE_ID_MIN = 8'h01;
   localparam logic [7:0] NODE_ID_MAX = 8'h7f;
   localparam logic [7:0] SER_RATE_RST = 8'h04;
   localparam logic [7:0] SER_RATE_MAX = 8'h08;
   localparam logic [7:0] CAN_RATE_RST = 8'h05;
   localparam logic [7:0] CAN_RATE_MAX = 8'h08;
   localparam logic [7:0] CAN_RATE_10K = 8'h01;
   localparam logic [7:0] CAN_RATE_800K = 8'h07;
   localparam logic [15:0] ACTION_RST = 16'h0000;
   localparam logic [15:0] FAULT_RST = 16'h0000;
   localparam logic [15:0] CMD_RST = 16'h0000;
   // ==========================================
   // Action codes
   localparam logic [15:0] ACT_NONE = 16'h0000;
   localparam logic [15:0] ACT_DISABLE = 16'h0002;
   localparam logic [15:0] ACT_QSTOP = 16'h0003;
   // ==========================================
   // Error codes
   localparam logic [15:0] ERR_GENERIC = 16'h1000;
   localparam logic [15:0] ERR_OVERCUR = 16'h2310;
   localparam logic [15:0] ERR_OVERVOLT = 16'h3210;
   localparam logic [15:0] ERR_UNDERVOLT = 16'h3220;
   localparam logic [15:0] ERR_OVERTEMP = 16'h4210;
   localparam logic [15:0] ERR_CURDET = 16'h5210;
   localparam logic [15:0] ERR_SOFTWARE = 16'h6100;
   localparam logic [15:0] ERR_ENC_LINK = 16'h7300;
   localparam logic [15:0] ERR_ENC_DISC = 16'h7305;
   localparam logic [15:0] ERR_OVERSPEED = 16'h7310;
   localparam logic [15:0] ERR_MAXVEL = 16'h8400;
   localparam logic [15:0] ERR_FOLLOW = 16'h8611;
   localparam logic [15:0] ERR_HALL = 16'hff01;
   localparam logic [15:0] ERR_OVERLOAD = 16'hff02;
   // Error register bit masks
   localparam logic [7:0] EREG_GENERIC = 8'h01;
   localparam logic [7:0] EREG_CURRENT = 8'h02;
   localparam logic [7:0] EREG_VOLTAGE = 8'h04;
   localparam logic [7:0] EREG_TEMP = 8'h08;
   localparam logic [7:0] EREG_PROFILE = 8'h20;
   localparam logic [7:0] EREG_MANUF = 8'h80;
   // ==========================================
   // Command word bit positions
   localparam int CW_SWITCH_ON = 0;
   localparam int CW_EN_VOLT = 1;
   localparam int CW_QSTOP = 2;
   localparam int CW_EN_OP = 3;
   localparam int CW_FAULT_RST = 7;
   localparam int CW_HALT = 8;
   localparam int CW_MANUF_LO = 11;
   // ==========================================
   // Carriers
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] index;
      logic [7:0] sub;
      logic [15:0] data;
   } dcco_req_t;
   typedef struct packed {
      logic ack;
      logic err;
      logic [15:0] data;
   } dcco_rsp_t;
   typedef struct packed {
      logic shutdown;
      logic switch_on;
      logic disable_voltage;
      logic quick_stop;
      logic disable_op;
      logic enable_op;
      logic fault_reset;
      logic halt;
      logic [4:0] manuf;
   } dcco_cmd_t;
   typedef struct packed {
      logic [7:0] node_id;
      logic [7:0] ser_rate;
      logic [7:0] can_rate;
   } dcco_comm_t;
endpackage

//--- rtl/dcco_err_map.sv
// Error code to error-register bit association
module dcco_err_map (
   input wire logic [15:0] code,
   output logic [7:0] ereg_bits,
   output logic known
);
   import dcco_pkg::*;
   // ==========================================
   // Mapping
   always_comb begin
      known = 1'b1;
      case (code)
         ERR_OVERCUR: ereg_bits = EREG_CURRENT;
         ERR_OVERVOLT, ERR_UNDERVOLT: ereg_bits = EREG_VOLTAGE;
         ERR_OVERTEMP: ereg_bits = EREG_TEMP;
         ERR_SOFTWARE, ERR_OVERSPEED, ERR_FOLLOW, ERR_OVERLOAD: begin
            ereg_bits = EREG_PROFILE;
         end
         ERR_HALL: ereg_bits = EREG_MANUF;
         ERR_GENERIC, ERR_CURDET, ERR_ENC_LINK, ERR_ENC_DISC, ERR_MAXVEL: begin
            ereg_bits = EREG_GENERIC;
         end
         default: begin
            // Unlisted codes still flag something rather than vanish
            ereg_bits = EREG_GENERIC;
            known = 1'b0;
         end
      endcase
   end
endmodule

//--- rtl/dcco_cmd_decode.sv
// Command word decoder with fault reset edge detection
module dcco_cmd_decode (
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] word,
   output dcco_pkg::dcco_cmd_t cmd
);
   import dcco_pkg::*;
   logic fr_prev_r;
   logic fr_now;
   logic nfr;
   assign fr_now = word[CW_FAULT_RST];
   assign nfr = ~fr_now;
   // ==========================================
   // Previous fault reset bit
   always_ff @(posedge clk) begin
      if (reset) begin
         fr_prev_r <= 1'b0;
      end else begin
         fr_prev_r <= fr_now;
      end
   end
   // ==========================================
   // Pattern decode; state commands only valid with fault reset bit low, halt and manuf bits pass through ungated
   always_comb begin
      cmd.shutdown = nfr & (word[2:0] == 3'b110);
      cmd.switch_on = nfr & (word[2:0] == 3'b111);
      cmd.disable_voltage = nfr & ~word[CW_EN_VOLT];
      cmd.quick_stop = nfr & (word[2:1] == 2'b01);
      cmd.disable_op = nfr & (word[3:0] == 4'b0111);
      cmd.enable_op = nfr & (word[3:0] == 4'b1111);
      cmd.fault_reset = fr_now & ~fr_prev_r;
      cmd.halt = word[CW_HALT];
      cmd.manuf = word[15:CW_MANUF_LO];
   end
endmodule

//--- test/dcco_master_model.sv
// Fieldbus master model issuing object reads and writes
module dcco_master_model (
   input wire logic clk,
   output dcco_pkg::dcco_req_t req,
   input dcco_pkg::dcco_rsp_t rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   import dcco_pkg::*;
   initial req = '0;
   // ==========
   // Access
   // Waits an edge first so two calls never assign req in one time step
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
         input logic [15:0] wd, output logic [15:0] rd, output logic er);
      @(posedge clk);
      #1;
      req <= '{1'b1, wr, idx, sub, wd};
      @(posedge clk);
      #1;
      rd = rsp.data;
      er = rsp.err | !rsp.ack;
      req <= '0;
   endtask
endmodule

//--- test/dcco_bank_chk.sv
// Port checks for the object bank
module dcco_bank_chk #(
   parameter int AN_CHANNELS = 4
) (
   input wire logic clk,
   input wire logic reset,
   input dcco_pkg::dcco_req_t req,
   input dcco_pkg::dcco_rsp_t rsp,
   input wire logic restart,
   input wire logic err_valid,
   input wire logic [15:0] err_code,
   input wire logic err_serious,
   input dcco_pkg::dcco_comm_t comm_active,
   input dcco_pkg::dcco_comm_t comm_stored,
   input wire logic [7:0] error_register,
   input wire logic history_push,
   input wire logic [15:0] history_code,
   input wire logic react_disable,
   input wire logic react_quick_stop,
   input dcco_pkg::dcco_cmd_t cmd,
   input wire logic [15:0] cmd_word
);
   timeunit 1ns;
   timeprecision 1ps;
   import dcco_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // ==========
   // Sequences
   sequence wr_s(logic [15:0] i);
      req.valid && req.write && req.index == i;
   endsequence
   sequence pushed_s;
      history_push && history_code == $past(err_code);
   endsequence
   // ==========
   // Access
   ack_timing_a: assert property (rsp.ack == $past(req.valid))
      else $error("ack timing");
   ro_write_a: assert property ((wr_s(16'h5010) or wr_s(16'h603f)) |=> rsp.err)
      else $error("read-only write taken");
   id_range_a: assert property (wr_s(16'h5000) ##0
      (req.data == '0 || req.data > 16'h7f) |=> rsp.err && $stable(comm_stored.node_id))
      else $error("bad node id taken");
   can_bad_a: assert property (wr_s(16'h5002) ##0 (req.data inside {16'h1, 16'h7})
      |=> rsp.err)
      else $error("unsupported rate taken");
   // ==========
   // Restart
   hold_comm_a: assert property (!restart |=> $stable(comm_active))
      else $error("active settings moved");
   restart_apply_a: assert property (restart |=> comm_active == $past(comm_stored))
      else $error("restart not applied");
   // ==========
   // Errors and commands
   err_push_a: assert property (err_valid |=> pushed_s)
      else $error("history push");
   serious_dis_a: assert property (err_valid && err_serious
      |=> react_disable && !react_quick_stop)
      else $error("serious error");
   no_react_a: assert property (!err_valid |=> !react_disable && !react_quick_stop)
      else $error("spurious reaction");
   hall_bit_a: assert property (err_valid && err_code == 16'hff01
      |=> error_register == 8'h80)
      else $error("hall bit");
   ereg_clear_a: assert property (cmd.fault_reset && !err_valid
      |=> error_register == 8'h00)
      else $error("error bits not cleared");
   fault_rst_a: assert property (cmd.fault_reset == (cmd_word[7] && !$past(cmd_word[7])))
      else $error("fault reset edge");
   enable_dec_a: assert property (cmd.enable_op ==
      (!cmd_word[7] && cmd_word[3:0] == 4'hf))
      else $error("enable decode");
endmodule
bind dcco_bank dcco_bank_chk #(.AN_CHANNELS(AN_CHANNELS)) i_dcco_bank_chk (.clk(clk),
   .reset(reset), .req(req), .rsp(rsp), .restart(restart), .err_valid(err_valid),
   .err_code(err_code), .err_serious(err_serious), .comm_active(comm_active),
   .comm_stored(comm_stored), .error_register(error_register),
   .history_push(history_push), .history_code(history_code), .react_disable(react_disable),
   .react_quick_stop(react_quick_stop), .cmd(cmd), .cmd_word(cmd_word));

//--- test/tb.sv
// Self-checking bench for the object bank
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dcco_pkg::*;
   logic clk, reset, restart, err_valid, err_serious, history_push, react_disable;
   logic react_quick_stop, er, e;
   logic [63:0] analog_in;
   logic [15:0] err_code, cmd_word, history_code, rd, w, prv;
   logic [7:0] error_register, v;
   logic [15:0] acts [4] = '{16'h0, 16'h2, 16'h3, 16'h7fff};
   logic [15:0] codes [14] = '{16'h1000, 16'h2310, 16'h3210, 16'h3220, 16'h4210,
      16'h5210, 16'h6100, 16'h7300, 16'h7305, 16'h7310, 16'h8400, 16'h8611, 16'hff01,
      16'hff02};
   dcco_req_t req;
   dcco_rsp_t rsp;
   dcco_comm_t comm_active, comm_stored;
   dcco_cmd_t cmd;
   int err_total, samples_checked;
   dcco_bank i_dcco_bank (.clk(clk), .reset(reset), .req(req), .rsp(rsp),
      .restart(restart), .analog_in(analog_in), .err_valid(err_valid), .err_code(err_code),
      .err_serious(err_serious), .comm_active(comm_active), .comm_stored(comm_stored),
      .error_register(error_register), .history_push(history_push),
      .history_code(history_code), .react_disable(react_disable),
      .react_quick_stop(react_quick_stop), .cmd(cmd), .cmd_word(cmd_word));
   dcco_master_model i_dcco_master_model (.clk(clk), .req(req), .rsp(rsp));
   // ==========
   // Helpers
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (!ok) begin
         err_total++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic acc(input logic wr, input logic [15:0] i, input logic [7:0] s,
         input logic [15:0] d, input logic xe, input logic [15:0] xd);
      i_dcco_master_model.xfer(wr, i, s, d, rd, er);
      chk(er === xe && rd === xd, "access");
   endtask
   function automatic logic [7:0] ereg_of(input logic [15:0] c);
      case (c)
         16'h2310: return 8'h02;
         16'h3210, 16'h3220: return 8'h04;
         16'h4210: return 8'h08;
         16'h6100, 16'h7310, 16'h8611, 16'hff02: return 8'h20;
         16'hff01: return 8'h80;
         default: return 8'h01;
      endcase
   endfunction
   function automatic dcco_cmd_t cmd_of(input logic [15:0] x, input logic p);
      dcco_cmd_t c;
      c.shutdown = !x[7] && x[2:0] == 3'h6;
      c.switch_on = !x[7] && x[2:0] == 3'h7;
      c.disable_voltage = !x[7] && !x[1];
      c.quick_stop = !x[7] && x[2:1] == 2'h1;
      c.disable_op = !x[7] && x[3:0] == 4'h7;
      c.enable_op = !x[7] && x[3:0] == 4'hf;
      c.fault_reset = x[7] && !p;
      c.halt = x[8];
      c.manuf = x[15:11];
      return c;
   endfunction
   task automatic fault(input logic [15:0] c, input logic s, input logic xd, input logic xq);
      @(posedge clk);
      #1;
      err_code <= c;
      err_serious <= s;
      err_valid <= 1'b1;
      @(posedge clk);
      #1;
      err_valid <= 1'b0;
      chk(error_register === ereg_of(c), "error bits");
      chk(history_push === 1'b1 && history_code === c, "history");
      chk(react_disable === xd && react_quick_stop === xq, "reaction");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ==========
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #100000;
      err_total++;
      final_report();
   end
   // ==========
   // Tests
   initial begin
      reset = 1'b1;
      restart = 1'b0;
      err_valid = 1'b0;
      err_serious = 1'b0;
      err_code = '0;
      analog_in = '0;
      err_total = 0;
      samples_checked = 0;
      w = 16'($urandom(32'hcabd9f91));
      repeat (10) @(posedge clk);
      #1;
      reset = 1'b0;
      acc(1'b0, 16'h5000, '0, '0, 1'b0, 16'h1);
      acc(1'b0, 16'h5001, '0, '0, 1'b0, 16'h4);
      acc(1'b0, 16'h5002, '0, '0, 1'b0, 16'h5);
      acc(1'b0, 16'h6007, '0, '0, 1'b0, 16'h0);
      acc(1'b0, 16'h603f, '0, '0, 1'b0, 16'h0);
      acc(1'b0, 16'h5003, '0, '0, 1'b1, 16'h0);
      v = 8'($urandom_range(126, 1));
      acc(1'b1, 16'h5000, '0, 16'h0000, 1'b1, '0);
      acc(1'b1, 16'h5000, '0, 16'h0080, 1'b1, '0);
      acc(1'b1, 16'h5000, '0, 16'h017f, 1'b1, '0);
      acc(1'b1, 16'h5000, '0, 16'h007f, 1'b0, '0);
      acc(1'b1, 16'h5000, '0, {8'h00, v}, 1'b0, '0);
      acc(1'b0, 16'h5000, '0, '0, 1'b0, {8'h00, v});
      for (int k = 0; k < 10; k++) begin
         acc(1'b1, 16'h5001, '0, 16'(k), k > 8, '0);
         acc(1'b1, 16'h5002, '0, 16'(k), k > 8 || k == 1 || k == 7, '0);
      end
      acc(1'b0, 16'h5002, '0, '0, 1'b0, 16'h8);
      chk(comm_active === {8'h01, 8'h04, 8'h05}, "applied early");
      // Settings are all written before the restart that applies them
      restart = 1'b1;
      @(posedge clk);
      #1;
      restart = 1'b0;
      chk(comm_active === {v, 8'h08, 8'h08}, "restart");
      for (int k = 0; k < 4; k++) analog_in[16*k +: 16] = 16'($urandom);
      for (int k = 0; k < 4; k++) begin
         acc(1'b0, 16'h5010, 8'(k + 1), '0, 1'b0, analog_in[16*k +: 16]);
      end
      acc(1'b0, 16'h5010, '0, '0, 1'b0, 16'h4);
      acc(1'b1, 16'h5010, 8'h01, 16'h1234, 1'b1, '0);
      for (int k = 0; k < 14; k++) begin
         w = acts[k % 4];
         e = 1'($urandom);
         acc(1'b1, 16'h6007, '0, w, 1'b0, '0);
         fault(codes[k], e, e || w == 16'h2, !e && w == 16'h3);
         acc(1'b0, 16'h603f, '0, '0, 1'b0, codes[k]);
      end
      acc(1'b1, 16'h603f, '0, '0, 1'b1, '0);
      prv = '0;
      for (int k = 0; k < 40; k++) begin
         w = 16'($urandom);
         w[7] = k[1];
         i_dcco_master_model.xfer(1'b1, 16'h6040, '0, w, rd, er);
         chk(er === 1'b0 && cmd_word === w, "command word");
         chk(cmd === cmd_of(w, prv[7]), "decode");
         prv = w;
      end
      acc(1'b0, 16'h6040, '0, '0, 1'b0, prv);
      chk(error_register === 8'h00, "fault reset clear");
      final_report();
   end
endmodule
